// ---- common/bdr_pkg.sv ----
package bdr_pkg;
    // ****************************************
    // status/control bit positions
    // ****************************************
    localparam int BDR_PERMIT_BIT  = 7;
    localparam int BDR_ACTIVE_BIT  = 6;
    localparam int BDR_BKEN_BIT    = 5;
    localparam int BDR_FTS_BIT     = 4;
    localparam int BDR_CLKSEL_BIT  = 3;
    localparam int BDR_WS_BIT      = 2;
    localparam int BDR_WSF_BIT     = 1;
    localparam int BDR_DVF_BIT     = 0;
    localparam int BDR_FRC_BIT     = 0;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0]  BDR_CTRL_RST  = 8'h00;
    localparam logic [15:0] BDR_BKPT_RST  = 16'h0000;
    localparam logic [7:0]  BDR_CMPA_RST  = 8'h00;
    localparam logic [7:0]  BDR_FRC_READ  = 8'h00;

    // serial command and program-write strobes from the link decoder
    typedef struct packed {
        logic        status_rd;   // read status/control
        logic        ctrl_wr;     // write status/control
        logic        bkpt_rd;     // breakpoint_read_command
        logic        bkpt_wr;     // breakpoint_write_command
        logic        frc_wr;      // serial write-byte to force-reset
        logic        cpu_frc_wr;  // program write to force-reset
        logic        cpu_cmpa_wr; // program write to comparator a high
        logic        background;  // background command
        logic        mem_fail;    // memory command clashed with wait/stop
        logic [15:0] wdata;
    } bdr_cmd_t;

    // cpu status inputs
    typedef struct packed {
        logic        halted;      // cpu in background
        logic        wait_stop;   // cpu in wait or stop
        logic [15:0] addr;        // cpu address bus
        logic        bus_cycle;   // address valid
        logic        trig_armed;  // trigger module armed
    } bdr_cpu_t;

    typedef struct packed {
        logic [7:0]  ctrl;
        logic [15:0] bkpt;
        logic [7:0]  cmpa;
        logic [15:0] rdata;
        logic        rvalid;
        logic        force_brk;
        logic        tag_brk;
        logic        bg_req;
        logic        sys_reset;
        logic        ws_bg;       // background entered from wait/stop
    } bdr_state_t;
endpackage : bdr_pkg

// ---- verilog/bdr_ctrl.sv ----
// Functional notes
// - permit bit 7 low blocks any halt request; high allows background entry.
// - permit bit stays set until normal reset clears it.
// - bit 6 reads 1 while cpu halted in background, else 0.
// - bit 5 low disables breakpoint; force/tag and address ignored.
// - force select 1: address match forces background at next instruction boundary.
// - force select 0: address match only tags the fetched opcode.
// - bit 3 selects comm clock; resets 0 alternate, 1 bus clock.
// - bit 2 reads 1 in wait/stop or background entered from it.
// - background command still pulls cpu out of wait/stop.
// - bit 1 set when memory command fails due to wait/stop.
// - bit 0 data-valid failure never reports a failure.
// - status/control reachable only by serial status and control commands.
// - 16-bit breakpoint address only through serial breakpoint commands.
// - force-reset reads 0x00 always and resets to zero.
// - program writes to force-reset are ignored; here one in the same cycle as a serial write blocks its reset.
// - serial write of 1 to force-reset bit 0 resets system.
// - trigger module has nine bytes of cpu-visible registers.
// - comparator a high resets 0x00, readable, ignores writes when armed.
// - permit bit unwritable while background active.
// - four status bits never change via control write.
`timescale 1ns/1ps
module bdr_ctrl
    import bdr_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire bdr_cmd_t    cmd,
    input  wire bdr_cpu_t    cpu,
    output logic [15:0]      rdata,
    output logic             rvalid,
    output logic             comm_clock_select,
    output logic [7:0]       comparator_a_high,
    output logic             force_brk,
    output logic             tag_brk,
    output logic             bg_req,
    output logic             sys_reset
);
    bdr_state_t st_reg;
    bdr_state_t st_next;
    logic       match;

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        st_next = st_reg;
        st_next.rvalid    = 1'b0;
        st_next.sys_reset = 1'b0;
        // live status bits, never from control write
        st_next.ctrl[BDR_ACTIVE_BIT] = cpu.halted;
        st_next.ctrl[BDR_DVF_BIT]    = 1'b0;
        st_next.ws_bg = st_reg.ws_bg;
        if (cmd.background && cpu.wait_stop) begin
            st_next.ws_bg = 1'b1;
        end else if (!cpu.halted && !cpu.wait_stop) begin
            st_next.ws_bg = 1'b0;
        end
        st_next.ctrl[BDR_WS_BIT] = cpu.wait_stop || st_next.ws_bg;
        // failure flag: set on clash, cleared when next background starts
        if (cmd.mem_fail) begin
            st_next.ctrl[BDR_WSF_BIT] = 1'b1;
        end else if (cmd.background) begin
            st_next.ctrl[BDR_WSF_BIT] = 1'b0;
        end
        // control write touches only control bits
        if (cmd.ctrl_wr) begin
            st_next.ctrl[BDR_BKEN_BIT]   = cmd.wdata[BDR_BKEN_BIT];
            st_next.ctrl[BDR_FTS_BIT]    = cmd.wdata[BDR_FTS_BIT];
            st_next.ctrl[BDR_CLKSEL_BIT] = cmd.wdata[BDR_CLKSEL_BIT];
            // permit only sets, only outside background
            if (!cpu.halted && cmd.wdata[BDR_PERMIT_BIT]) begin
                st_next.ctrl[BDR_PERMIT_BIT] = 1'b1;
            end
        end
        if (cmd.bkpt_wr) begin
            st_next.bkpt = cmd.wdata;
        end
        // read answers
        if (cmd.status_rd) begin
            st_next.rdata  = {8'h00, st_reg.ctrl};
            st_next.rvalid = 1'b1;
        end else if (cmd.bkpt_rd) begin
            st_next.rdata  = st_reg.bkpt;
            st_next.rvalid = 1'b1;
        end
        // force reset: serial only, self-clearing
        if (cmd.frc_wr && !cmd.cpu_frc_wr && cmd.wdata[BDR_FRC_BIT]) begin
            st_next.sys_reset = 1'b1;
        end
        // comparator a high, cpu-visible trigger byte, locked while armed
        if (cmd.cpu_cmpa_wr && !cpu.trig_armed) begin
            st_next.cmpa = cmd.wdata[7:0];
        end
        // breakpoint requests
        st_next.force_brk = match && st_reg.ctrl[BDR_FTS_BIT];
        st_next.tag_brk   = match && !st_reg.ctrl[BDR_FTS_BIT];
        st_next.bg_req    = st_reg.ctrl[BDR_PERMIT_BIT]
                            && cmd.background;
    end

    // full sixteen-bit address compare, gated by enable and permit
    assign match = cpu.bus_cycle && st_reg.ctrl[BDR_BKEN_BIT]
                   && st_reg.ctrl[BDR_PERMIT_BIT]
                   && (cpu.addr == st_reg.bkpt);

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_reg       <= '0;
            st_reg.ctrl  <= BDR_CTRL_RST;
            st_reg.bkpt  <= BDR_BKPT_RST;
            st_reg.cmpa  <= BDR_CMPA_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flops
    assign rdata             = st_reg.rdata;
    assign rvalid            = st_reg.rvalid;
    assign comm_clock_select = st_reg.ctrl[BDR_CLKSEL_BIT];
    assign comparator_a_high = st_reg.cmpa;
    assign force_brk         = st_reg.force_brk;
    assign tag_brk           = st_reg.tag_brk;
    assign bg_req            = st_reg.bg_req;
    assign sys_reset         = st_reg.sys_reset;

    // ****************************************
    // assertions
    // ****************************************
    property p_permit_sticky;
        @(posedge sys_clk) disable iff (!rst_n)
        st_reg.ctrl[BDR_PERMIT_BIT] |=> st_reg.ctrl[BDR_PERMIT_BIT];
    endproperty
    a_permit_sticky: assert property (p_permit_sticky)
        else $error("permit bit dropped");

    property p_no_halt_req;
        @(posedge sys_clk) disable iff (!rst_n)
        !st_reg.ctrl[BDR_PERMIT_BIT] |=> !bg_req && !force_brk && !tag_brk;
    endproperty
    a_no_halt_req: assert property (p_no_halt_req)
        else $error("halt request without permit");

    property p_active;
        @(posedge sys_clk) disable iff (!rst_n)
        cpu.halted |=> st_reg.ctrl[BDR_ACTIVE_BIT];
    endproperty
    a_active: assert property (p_active)
        else $error("active bit wrong");

    property p_bk_off;
        @(posedge sys_clk) disable iff (!rst_n)
        !st_reg.ctrl[BDR_BKEN_BIT] |=> !force_brk && !tag_brk;
    endproperty
    a_bk_off: assert property (p_bk_off)
        else $error("break while disabled");

    property p_force;
        @(posedge sys_clk) disable iff (!rst_n)
        match && st_reg.ctrl[BDR_FTS_BIT] |=> force_brk && !tag_brk;
    endproperty
    a_force: assert property (p_force)
        else $error("force break missing");

    property p_tag;
        @(posedge sys_clk) disable iff (!rst_n)
        match && !st_reg.ctrl[BDR_FTS_BIT] |=> tag_brk && !force_brk;
    endproperty
    a_tag: assert property (p_tag)
        else $error("tag break missing");

    property p_ws;
        @(posedge sys_clk) disable iff (!rst_n)
        cpu.wait_stop |=> st_reg.ctrl[BDR_WS_BIT];
    endproperty
    a_ws: assert property (p_ws)
        else $error("wait/stop bit not set");

    property p_wsf;
        @(posedge sys_clk) disable iff (!rst_n)
        cmd.mem_fail |=> st_reg.ctrl[BDR_WSF_BIT];
    endproperty
    a_wsf: assert property (p_wsf)
        else $error("failure flag not set");

    property p_dvf;
        @(posedge sys_clk) disable iff (!rst_n)
        cmd.status_rd |=> rvalid && !rdata[BDR_DVF_BIT];
    endproperty
    a_dvf: assert property (p_dvf)
        else $error("data valid failure reported");

    property p_frc;
        @(posedge sys_clk) disable iff (!rst_n)
        cmd.frc_wr && !cmd.cpu_frc_wr && cmd.wdata[BDR_FRC_BIT]
            |=> sys_reset ##1 (!sys_reset || $past(cmd.frc_wr));
    endproperty
    a_frc: assert property (p_frc)
        else $error("force reset pulse wrong");

    property p_frc_cpu;
        @(posedge sys_clk) disable iff (!rst_n)
        (!cmd.frc_wr || cmd.cpu_frc_wr) |=> !sys_reset;
    endproperty
    a_frc_cpu: assert property (p_frc_cpu)
        else $error("reset without serial write");

    property p_cmpa_lock;
        @(posedge sys_clk) disable iff (!rst_n)
        cpu.trig_armed |=> $stable(comparator_a_high);
    endproperty
    a_cmpa_lock: assert property (p_cmpa_lock)
        else $error("comparator written while armed");

    property p_permit_lock;
        @(posedge sys_clk) disable iff (!rst_n)
        cpu.halted && !st_reg.ctrl[BDR_PERMIT_BIT] |=> !st_reg.ctrl[BDR_PERMIT_BIT];
    endproperty
    a_permit_lock: assert property (p_permit_lock)
        else $error("permit written in background");

    // register access paths
    property p_dvf_zero;
        @(posedge sys_clk) disable iff (!rst_n)
        !st_reg.ctrl[BDR_DVF_BIT];
    endproperty
    a_dvf_zero: assert property (p_dvf_zero)
        else $error("data valid failure bit set");

    property p_status_rd;
        @(posedge sys_clk) disable iff (!rst_n)
        cmd.status_rd |=> rvalid && (rdata == {8'h00, $past(st_reg.ctrl)});
    endproperty
    a_status_rd: assert property (p_status_rd)
        else $error("status read data wrong");

    property p_bkpt_wr;
        @(posedge sys_clk) disable iff (!rst_n)
        cmd.bkpt_wr |=> st_reg.bkpt == $past(cmd.wdata);
    endproperty
    a_bkpt_wr: assert property (p_bkpt_wr)
        else $error("breakpoint write lost");

    property p_bkpt_rd;
        @(posedge sys_clk) disable iff (!rst_n)
        cmd.bkpt_rd && !cmd.status_rd |=> rvalid && (rdata == $past(st_reg.bkpt));
    endproperty
    a_bkpt_rd: assert property (p_bkpt_rd)
        else $error("breakpoint read data wrong");

    property p_ctrl_wsf;
        @(posedge sys_clk) disable iff (!rst_n)
        cmd.ctrl_wr && !cmd.mem_fail && !cmd.background
            |=> st_reg.ctrl[BDR_WSF_BIT] == $past(st_reg.ctrl[BDR_WSF_BIT]);
    endproperty
    a_ctrl_wsf: assert property (p_ctrl_wsf)
        else $error("failure flag changed by control write");

    property p_clk_sel;
        @(posedge sys_clk) disable iff (!rst_n)
        cmd.ctrl_wr |=> comm_clock_select == $past(cmd.wdata[BDR_CLKSEL_BIT]);
    endproperty
    a_clk_sel: assert property (p_clk_sel)
        else $error("clock select not written");

    property p_permit_set;
        @(posedge sys_clk) disable iff (!rst_n)
        cmd.ctrl_wr && cmd.wdata[BDR_PERMIT_BIT] && !cpu.halted
            |=> st_reg.ctrl[BDR_PERMIT_BIT];
    endproperty
    a_permit_set: assert property (p_permit_set)
        else $error("permit write outside background lost");

    property p_addr_miss;
        @(posedge sys_clk) disable iff (!rst_n)
        cpu.bus_cycle && (cpu.addr != st_reg.bkpt) |=> !force_brk && !tag_brk;
    endproperty
    a_addr_miss: assert property (p_addr_miss)
        else $error("break on address mismatch");

    property p_wake;
        @(posedge sys_clk) disable iff (!rst_n)
        cmd.background && cpu.wait_stop && st_reg.ctrl[BDR_PERMIT_BIT]
            |=> bg_req && st_reg.ctrl[BDR_WS_BIT];
    endproperty
    a_wake: assert property (p_wake)
        else $error("background from wait/stop not taken");

    property p_frc_src;
        @(posedge sys_clk) disable iff (!rst_n)
        sys_reset |-> $past(cmd.frc_wr) && !$past(cmd.cpu_frc_wr);
    endproperty
    a_frc_src: assert property (p_frc_src)
        else $error("force reset held without serial write");

    property p_cmpa_wr;
        @(posedge sys_clk) disable iff (!rst_n)
        cmd.cpu_cmpa_wr && !cpu.trig_armed
            |=> comparator_a_high == $past(cmd.wdata[7:0]);
    endproperty
    a_cmpa_wr: assert property (p_cmpa_wr)
        else $error("comparator write lost while disarmed");

    c_force: cover property (@(posedge sys_clk) disable iff (!rst_n) force_brk);
    c_tag: cover property (@(posedge sys_clk) disable iff (!rst_n) tag_brk);
    c_reset: cover property (@(posedge sys_clk) disable iff (!rst_n) sys_reset);
    c_wsbg: cover property (@(posedge sys_clk) disable iff (!rst_n) bg_req && cpu.wait_stop);
endmodule : bdr_ctrl

// ---- dv/bdr_host_model.sv ----
`timescale 1ns/1ps
module bdr_host_model
    import bdr_pkg::*;
(
    input  wire logic sys_clk,
    output bdr_cmd_t  cmd
);
    // ****
    // serial host
    // ****
    initial cmd = '0;

    // one strobe per command, dropped at the next edge
    task automatic issue(input bdr_cmd_t c);
        @(posedge sys_clk);
        cmd <= c;
        @(posedge sys_clk);
        cmd <= '0;
    endtask : issue
endmodule : bdr_host_model

// ---- dv/background_debug_ctrl_regs_tb.sv ----
`timescale 1ns/1ps
module background_debug_ctrl_regs_tb;
    import bdr_pkg::*;
    localparam logic [8:0] F_STAT = 9'h100;
    localparam logic [8:0] F_CTRL = 9'h080;
    localparam logic [8:0] F_BKRD = 9'h040;
    localparam logic [8:0] F_BKWR = 9'h020;
    localparam logic [8:0] F_FRC  = 9'h010;
    localparam logic [8:0] F_CFRC = 9'h008;
    localparam logic [8:0] F_CMPA = 9'h004;
    localparam logic [8:0] F_BG   = 9'h002;
    localparam logic [8:0] F_FAIL = 9'h001;
    logic        sys_clk;
    logic        rst_n;
    bdr_cmd_t    cmd;
    bdr_cpu_t    cpu;
    logic [15:0] rdata;
    logic        rvalid;
    logic        comm_clock_select;
    logic [7:0]  comparator_a_high;
    logic        force_brk;
    logic        tag_brk;
    logic        bg_req;
    logic        sys_reset;
    logic [15:0] exp_q[$];
    int          fails;
    int          num_checks;
    int          seed;
    logic [15:0] bk_addr;
    logic [7:0]  cval;

    bdr_host_model u_host (.sys_clk(sys_clk), .cmd(cmd));
    bdr_ctrl u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .cmd(cmd), .cpu(cpu), .rdata(rdata),
        .rvalid(rvalid), .comm_clock_select(comm_clock_select),
        .comparator_a_high(comparator_a_high), .force_brk(force_brk),
        .tag_brk(tag_brk), .bg_req(bg_req), .sys_reset(sys_reset)
    );

    // ****
    // helpers
    // ****
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want) begin
            fails++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : chk

    task automatic send(input logic [8:0] f, input logic [15:0] d);
        u_host.issue({f, d});
        #1;
    endtask : send

    task automatic rd(input logic [8:0] f, input logic [15:0] want);
        exp_q.push_back(want);
        send(f, 16'h0000);
    endtask : rd

    task automatic pul(input logic [3:0] want);
        chk({12'h000, force_brk, tag_brk, bg_req, sys_reset}, {12'h000, want});
    endtask : pul

    task automatic bus(input logic [15:0] a, input logic [3:0] want);
        @(posedge sys_clk);
        cpu.addr <= a;
        cpu.bus_cycle <= 1'b1;
        @(posedge sys_clk);
        cpu.bus_cycle <= 1'b0;
        #1;
        pul(want);
    endtask : bus

    task automatic wrap_up();
        if (exp_q.size() != 0) fails++;
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    // ****
    // clock, read monitor, watchdog
    // ****
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(negedge sys_clk) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() > 0) chk(rdata, exp_q.pop_front());
            else chk({15'h0000, rvalid}, 16'h0000);
        end
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        wrap_up();
    end

    // ****
    // main sequence
    // ****
    initial begin
        seed = 4643;
        rst_n = 1'b0;
        cpu = '0;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        chk({15'h0000, comm_clock_select}, 16'h0000);
        chk({8'h00, comparator_a_high}, 16'h0000);
        rd(F_STAT, 16'h0000);
        send(F_BG, 16'h0000);
        pul(4'b0000);
        send(F_CTRL, 16'h00ff);
        chk({15'h0000, comm_clock_select}, 16'h0001);
        rd(F_STAT, 16'h00b8);
        send(F_CTRL, 16'h0000);
        rd(F_STAT, 16'h0080);
        // breakpoint programmed while halted
        bk_addr = 16'($random(seed));
        @(posedge sys_clk) cpu.halted <= 1'b1;
        send(F_BKWR, bk_addr);
        rd(F_BKRD, bk_addr);
        @(posedge sys_clk) cpu.halted <= 1'b0;
        // force, tag, then disabled
        for (int i = 0; i < 3; i++) begin
            send(F_CTRL, 16'(24'hb0a090 >> (8 * (2 - i))) & 16'h00ff);
            bus(bk_addr, 4'(12'h840 >> (4 * (2 - i))));
            bus(bk_addr ^ (i == 0 ? 16'h8000 : 16'h0001), 4'b0000);
        end
        @(posedge sys_clk) cpu.halted <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rd(F_STAT, 16'h00d0);
        @(posedge sys_clk) cpu.halted <= 1'b0;
        cpu.wait_stop <= 1'b1;
        repeat (2) @(posedge sys_clk);
        send(F_FAIL, 16'h0000);
        rd(F_STAT, 16'h0096);
        send(F_BG, 16'h0000);
        pul(4'b0010);
        @(posedge sys_clk) cpu.wait_stop <= 1'b0;
        cpu.halted <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rd(F_STAT, 16'h00d4);
        @(posedge sys_clk) cpu.halted <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rd(F_STAT, 16'h0090);
        // serial, serial+program, program, bit clear
        send(F_FRC, 16'h0001);
        pul(4'b0001);
        send(F_FRC | F_CFRC, 16'h0001);
        pul(4'b0000);
        send(F_CFRC, 16'h0001);
        pul(4'b0000);
        send(F_FRC, 16'h0000);
        pul(4'b0000);
        cval = 8'($random(seed));
        send(F_CMPA, {8'h00, cval});
        chk({8'h00, comparator_a_high}, {8'h00, cval});
        @(posedge sys_clk) cpu.trig_armed <= 1'b1;
        send(F_CMPA, {8'h00, ~cval});
        chk({8'h00, comparator_a_high}, {8'h00, cval});
        // mid-run reset clears permit and comparator
        @(posedge sys_clk) rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        chk({8'h00, comparator_a_high}, 16'h0000);
        @(posedge sys_clk) cpu.halted <= 1'b1;
        send(F_CTRL, 16'h0080);
        rd(F_STAT, 16'h0040);
        @(posedge sys_clk) cpu.halted <= 1'b0;
        send(F_BG, 16'h0000);
        pul(4'b0000);
        send(F_CTRL, 16'h0080);
        rd(F_STAT, 16'h0080);
        repeat (2) @(posedge sys_clk);
        wrap_up();
    end
endmodule : background_debug_ctrl_regs_tb
